// file: logic/csrf_pkg.sv
// Shared constants, operation codes, states and carriers of the core register and stack block
package csrf_pkg;

	localparam int          CSRF_RF_DEPTH       = 32;
	localparam int          CSRF_RF_AW          = 5;
	localparam int          CSRF_SP_W           = 16;
	localparam int          CSRF_RA_W           = 24;
	localparam int          CSRF_SMALL_PM_LOG2  = 17;
	localparam int          CSRF_PC_W_MIN       = 8;
	localparam int          CSRF_PC_W_MAX       = 22;
	localparam logic [4:0]  CSRF_PTR_X_LO       = 5'h1A;
	localparam logic [4:0]  CSRF_PTR_Y_LO       = 5'h1C;
	localparam logic [4:0]  CSRF_PTR_Z_LO       = 5'h1E;
	localparam logic [7:0]  CSRF_IO_SP_LO       = 8'h3D;
	localparam logic [7:0]  CSRF_IO_SP_HI       = 8'h3E;
	localparam logic [2:0]  CSRF_IRQ_BLOCK_INSNS = 3'h4;
	localparam logic [15:0] CSRF_SRAM_TOP_DFLT  = 16'h3FFF;
	localparam logic [7:0]  CSRF_REG_RST        = 8'h00;

	typedef enum logic [2:0] {
		CSRF_OP_NONE = 3'h0,
		CSRF_OP_PUSH = 3'h1,
		CSRF_OP_POP  = 3'h2,
		CSRF_OP_CALL = 3'h3,
		CSRF_OP_RET  = 3'h4,
		CSRF_OP_RETURN_FROM_INTERRUPT = 3'h5,
		CSRF_OP_IRQ  = 3'h6,
		CSRF_OP_JUMP = 3'h7
	} csrf_op_e;

	typedef enum logic [2:0] {
		CSRF_ST_IDLE = 3'b001,
		CSRF_ST_CALL = 3'b010,
		CSRF_ST_RET  = 3'b100
	} csrf_state_e;

	typedef struct packed {
		logic [4:0]  ra;
		logic [4:0]  rb;
		logic        we;
		logic        wide;
		logic [4:0]  wa;
		logic [15:0] wd;
	} csrf_rf_req_s;

	typedef struct packed {
		csrf_op_e    op;
		logic [4:0]  reg_idx;
		logic [23:0] target;
	} csrf_stk_req_s;

	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] data;
	} csrf_io_wr_s;

endpackage

// file: logic/csrf_regfile.sv
// Working register file: 32 byte registers, byte and pair access, pointer views
`timescale 1ns/1ps
`default_nettype none
module csrf_regfile (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// Access request
	input  wire csrf_pkg::csrf_rf_req_s req,
	// Read data
	output logic [7:0]                  rdata_a,
	output logic [7:0]                  rdata_b,
	output logic [15:0]                 word_a,
	// Pointer views
	output logic [15:0]                 ptr_x,
	output logic [15:0]                 ptr_y,
	output logic [15:0]                 ptr_z
);
	import csrf_pkg::*;

	logic [7:0] regs_r [CSRF_RF_DEPTH];
	logic [4:0] wa_even;
	logic [4:0] ra_even;

	assign wa_even = {req.wa[4:1], 1'b0};
	assign ra_even = {req.ra[4:1], 1'b0};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < CSRF_RF_DEPTH; i++) begin
				regs_r[i] <= CSRF_REG_RST;
			end
		end else if (req.we) begin
			if (req.wide) begin
				regs_r[wa_even]        <= req.wd[7:0];
				regs_r[wa_even | 5'h01] <= req.wd[15:8];
			end else begin
				regs_r[req.wa] <= req.wd[7:0];
			end
		end
	end

	// Reads are combinational so that operand and result share one cycle
	assign rdata_a = regs_r[req.ra];
	assign rdata_b = regs_r[req.rb];
	assign word_a  = {regs_r[ra_even | 5'h01], regs_r[ra_even]};
	assign ptr_x   = {regs_r[CSRF_PTR_X_LO | 5'h01], regs_r[CSRF_PTR_X_LO]};
	assign ptr_y   = {regs_r[CSRF_PTR_Y_LO | 5'h01], regs_r[CSRF_PTR_Y_LO]};
	assign ptr_z   = {regs_r[CSRF_PTR_Z_LO | 5'h01], regs_r[CSRF_PTR_Z_LO]};
endmodule
`default_nettype wire

// file: logic/csrf_core.sv
// Instruction prefetch, stack pointer, call and return sequencing around the register file
`timescale 1ns/1ps
`default_nettype none
module csrf_core #(
	parameter int          PC_W     = 17,
	parameter logic [15:0] SRAM_TOP = csrf_pkg::CSRF_SRAM_TOP_DFLT
) (
	// Clock and reset
	input  wire logic                    CLOCK,
	input  wire logic                    RST_N,
	// Program memory
	output logic [PC_W-1:0]              PM_ADDR,
	input  wire logic [15:0]             PM_DATA,
	// Instruction to execution unit
	output logic [15:0]                  INSN,
	output logic                         INSN_VALID,
	output logic                         INSN_EXT,
	output logic [PC_W-1:0]              INSN_ADDR,
	input  wire logic                    EX_LONG,
	input  wire logic                    INSN_DONE,
	output logic                         STALL,
	// Register file
	input  wire csrf_pkg::csrf_rf_req_s  RF_REQ,
	output logic [7:0]                   RF_RDATA_A,
	output logic [7:0]                   RF_RDATA_B,
	output logic [15:0]                  RF_WORD_A,
	output logic [15:0]                  PTR_X,
	output logic [15:0]                  PTR_Y,
	output logic [15:0]                  PTR_Z,
	// Flash table read
	input  wire logic                    LPM_REQ,
	output logic [7:0]                   LPM_DATA,
	output logic                         LPM_VALID,
	// Stack and program flow
	input  wire csrf_pkg::csrf_stk_req_s STK_REQ,
	output logic                         IRQ_ACK,
	output logic                         RETURN_FROM_INTERRUPT_DONE,
	output logic                         IRQ_BLOCK,
	// I/O space access to the stack pointer
	input  wire csrf_pkg::csrf_io_wr_s   IO_WR,
	input  wire logic [7:0]              IO_RD_ADDR,
	output logic [7:0]                   IO_RDATA,
	// Data memory
	output logic [15:0]                  DM_ADDR,
	output logic [7:0]                   DM_WDATA,
	output logic                         DM_WE,
	output logic                         DM_RE,
	input  wire logic [7:0]              DM_RDATA
);
	import csrf_pkg::*;

	if (PC_W < CSRF_PC_W_MIN || PC_W > CSRF_PC_W_MAX) begin : g_chk_pc_w
		$error("PC_W outside the range the return address bytes can carry");
	end

	// Program bytes are twice the word count, hence the +1
	localparam int         RET_BYTES = (PC_W + 1 > CSRF_SMALL_PM_LOG2) ? 3 : 2;
	localparam logic [1:0] LAST_BYTE = 2'(RET_BYTES - 1);

	csrf_state_e      state_r;
	logic [1:0]       byte_cnt_r;
	logic [PC_W-1:0]  pc_r;
	logic [15:0]      ir_r;
	logic             ir_valid_r;
	logic             ir_ext_r;
	logic [PC_W-1:0]  ir_addr_r;
	logic [15:0]      sp_r;
	logic [23:0]      ret_addr_r;
	logic [23:0]      tgt_r;
	logic             is_return_from_interrupt_r;
	logic [2:0]       blk_cnt_r;
	logic [7:0]       lpm_data_r;
	logic             lpm_valid_r;

	logic             idle;
	logic             irq_take;
	logic             call_start;
	logic             ret_start;
	logic             flow_start;
	logic             jump;
	logic             push_byte;
	logic             pop_byte;
	logic             lpm;
	logic             last_byte;
	logic             load_pc;
	logic [23:0]      pop_word;
	logic [PC_W-1:0]  new_pc;
	logic             spl_wr;
	csrf_rf_req_s     rf_req;

	assign idle       = (state_r == CSRF_ST_IDLE);
	// Entry is refused while the pointer update window is open
	assign irq_take   = idle && (STK_REQ.op == CSRF_OP_IRQ) && (blk_cnt_r == 3'h0);
	assign call_start = idle && (STK_REQ.op == CSRF_OP_CALL);
	assign ret_start  = idle && (STK_REQ.op == CSRF_OP_RET || STK_REQ.op == CSRF_OP_RETURN_FROM_INTERRUPT);
	assign flow_start = call_start || irq_take || ret_start;
	assign jump       = idle && (STK_REQ.op == CSRF_OP_JUMP);
	assign push_byte  = idle && (STK_REQ.op == CSRF_OP_PUSH);
	assign pop_byte   = idle && (STK_REQ.op == CSRF_OP_POP);
	// Table reads share the program memory port, so they cost a fetch slot
	assign lpm        = LPM_REQ && idle && !flow_start && !jump;
	assign last_byte  = (byte_cnt_r == LAST_BYTE);
	assign load_pc    = !idle && last_byte;
	assign pop_word   = {ret_addr_r[15:0], DM_RDATA};
	assign new_pc     = (state_r == CSRF_ST_RET) ? pop_word[PC_W-1:0] : tgt_r[PC_W-1:0];
	assign spl_wr     = IO_WR.we && (IO_WR.addr == CSRF_IO_SP_LO);

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state_r    <= CSRF_ST_IDLE;
			byte_cnt_r <= 2'h0;
			is_return_from_interrupt_r  <= 1'b0;
		end else begin
			case (state_r)
				CSRF_ST_IDLE: begin
					byte_cnt_r <= 2'h0;
					if (call_start || irq_take) begin
						state_r <= CSRF_ST_CALL;
					end else if (ret_start) begin
						state_r   <= CSRF_ST_RET;
						is_return_from_interrupt_r <= (STK_REQ.op == CSRF_OP_RETURN_FROM_INTERRUPT);
					end
				end
				CSRF_ST_CALL, CSRF_ST_RET: begin
					if (last_byte) begin
						state_r    <= CSRF_ST_IDLE;
						byte_cnt_r <= 2'h0;
					end else begin
						byte_cnt_r <= byte_cnt_r + 2'h1;
					end
				end
				default: begin
					state_r    <= CSRF_ST_IDLE;
					byte_cnt_r <= 2'h0;
				end
			endcase
		end
	end

	// Prefetch: the word at pc_r is latched while the word in ir_r executes
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			pc_r       <= '0;
			ir_r       <= 16'h0000;
			ir_valid_r <= 1'b0;
			ir_ext_r   <= 1'b0;
			ir_addr_r  <= '0;
		end else if (load_pc || jump) begin
			pc_r       <= load_pc ? new_pc : STK_REQ.target[PC_W-1:0];
			ir_valid_r <= 1'b0;
			ir_ext_r   <= 1'b0;
		end else if (flow_start) begin
			ir_valid_r <= 1'b0;
		end else if (idle && !lpm) begin
			ir_r       <= PM_DATA;
			ir_addr_r  <= pc_r;
			ir_valid_r <= 1'b1;
			ir_ext_r   <= ir_valid_r && !ir_ext_r && EX_LONG;
			pc_r       <= pc_r + 1'b1;
		end
	end

	// Return address is shifted out low byte first and rebuilt high byte first
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			ret_addr_r <= 24'h000000;
			tgt_r      <= 24'h000000;
		end else if (call_start || irq_take) begin
			// An interrupt resumes the word not yet executed
			ret_addr_r <= (irq_take && ir_valid_r) ? 24'(ir_addr_r) : 24'(pc_r);
			tgt_r      <= STK_REQ.target;
		end else if (state_r == CSRF_ST_CALL) begin
			ret_addr_r <= {8'h00, ret_addr_r[23:8]};
		end else if (state_r == CSRF_ST_RET) begin
			ret_addr_r <= pop_word;
		end else if (ret_start) begin
			ret_addr_r <= 24'h000000;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			sp_r <= SRAM_TOP;
		end else if (push_byte || state_r == CSRF_ST_CALL) begin
			sp_r <= sp_r - 16'h0001;
		end else if (pop_byte || state_r == CSRF_ST_RET) begin
			sp_r <= sp_r + 16'h0001;
		end else if (spl_wr) begin
			sp_r[7:0] <= IO_WR.data;
		end else if (IO_WR.we && IO_WR.addr == CSRF_IO_SP_HI) begin
			sp_r[15:8] <= IO_WR.data;
		end
	end

	// Window closes on the fourth retired instruction or any other I/O write
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			blk_cnt_r <= 3'h0;
		end else if (spl_wr) begin
			blk_cnt_r <= CSRF_IRQ_BLOCK_INSNS;
		end else if (IO_WR.we) begin
			blk_cnt_r <= 3'h0;
		end else if (INSN_DONE && blk_cnt_r != 3'h0) begin
			blk_cnt_r <= blk_cnt_r - 3'h1;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			lpm_data_r  <= 8'h00;
			lpm_valid_r <= 1'b0;
		end else begin
			lpm_valid_r <= lpm;
			if (lpm) begin
				lpm_data_r <= PTR_Z[0] ? PM_DATA[15:8] : PM_DATA[7:0];
			end
		end
	end

	// A popped byte takes the write port from the execution unit
	always_comb begin
		rf_req = RF_REQ;
		if (pop_byte) begin
			rf_req.we   = 1'b1;
			rf_req.wide = 1'b0;
			rf_req.wa   = STK_REQ.reg_idx;
			rf_req.wd   = {8'h00, DM_RDATA};
		end
	end

	csrf_regfile u_regfile (
		.clk     (CLOCK),
		.rst_n   (RST_N),
		.req     (rf_req),
		.rdata_a (RF_RDATA_A),
		.rdata_b (RF_RDATA_B),
		.word_a  (RF_WORD_A),
		.ptr_x   (PTR_X),
		.ptr_y   (PTR_Y),
		.ptr_z   (PTR_Z)
	);

	// Stack accesses: push writes at the pointer, pop reads one above it
	always_comb begin
		DM_ADDR  = sp_r;
		DM_WDATA = 8'h00;
		DM_WE    = 1'b0;
		DM_RE    = 1'b0;
		if (state_r == CSRF_ST_CALL) begin
			DM_WDATA = ret_addr_r[7:0];
			DM_WE    = 1'b1;
		end else if (push_byte) begin
			DM_WDATA = RF_RDATA_A;
			DM_WE    = 1'b1;
		end else if (state_r == CSRF_ST_RET || pop_byte) begin
			DM_ADDR = sp_r + 16'h0001;
			DM_RE   = 1'b1;
		end
	end

	// The pointer holds a byte address, so its word address has one bit fewer
	assign PM_ADDR    = lpm ? PC_W'(PTR_Z[15:1]) : pc_r;
	assign INSN       = ir_r;
	assign INSN_VALID = ir_valid_r;
	assign INSN_EXT   = ir_ext_r;
	assign INSN_ADDR  = ir_addr_r;
	assign STALL      = !idle;
	assign IRQ_ACK    = irq_take;
	assign RETURN_FROM_INTERRUPT_DONE  = (state_r == CSRF_ST_RET) && last_byte && is_return_from_interrupt_r;
	assign IRQ_BLOCK  = (blk_cnt_r != 3'h0);
	assign LPM_DATA   = lpm_data_r;
	assign LPM_VALID  = lpm_valid_r;
	assign IO_RDATA   = (IO_RD_ADDR == CSRF_IO_SP_LO) ? sp_r[7:0] :
	                    (IO_RD_ADDR == CSRF_IO_SP_HI) ? sp_r[15:8] : 8'h00;
endmodule
`default_nettype wire

// file: verif/csrf_core_checker.sv
// Port-level assertions for the core stack and register block
`timescale 1ns/1ps
`default_nettype none
module csrf_core_checker #(
	parameter int PC_W = 17
) (
	input wire logic                    CLOCK,
	input wire logic                    RST_N,
	input wire logic [15:0]             PM_DATA,
	input wire logic [15:0]             INSN,
	input wire logic                    INSN_VALID,
	input wire logic                    STALL,
	input wire logic [15:0]             PTR_Z,
	input wire logic                    LPM_REQ,
	input wire logic [7:0]              LPM_DATA,
	input wire logic                    LPM_VALID,
	input wire csrf_pkg::csrf_stk_req_s STK_REQ,
	input wire logic                    IRQ_ACK,
	input wire logic                    RETURN_FROM_INTERRUPT_DONE,
	input wire logic                    IRQ_BLOCK,
	input wire csrf_pkg::csrf_io_wr_s   IO_WR,
	input wire logic [15:0]             DM_ADDR,
	input wire logic                    DM_WE,
	input wire logic                    DM_RE
);
	import csrf_pkg::*;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	logic quiet;
	// Only ops that leave the fetch running
	assign quiet = !STALL && STK_REQ.op inside {CSRF_OP_NONE, CSRF_OP_PUSH, CSRF_OP_POP};
	sequence s_call; !STALL && STK_REQ.op == CSRF_OP_CALL; endsequence
	sequence s_ret; !STALL && STK_REQ.op inside {CSRF_OP_RET, CSRF_OP_RETURN_FROM_INTERRUPT}; endsequence
	sequence s_push; !STALL && STK_REQ.op == CSRF_OP_PUSH; endsequence
	// Three bytes follow from the 17-bit program counter of this build
	sequence s_push3; (STALL && DM_WE)[*3] ##1 !STALL; endsequence
	sequence s_pop3; (STALL && DM_RE)[*3] ##1 !STALL; endsequence
	a_fetch_word: assert property (quiet && !LPM_REQ ##1 INSN_VALID |-> INSN == $past(PM_DATA))
		else $error("fetched word differs from memory");
	a_call_push: assert property (s_call |=> s_push3)
		else $error("call did not push three bytes");
	a_ret_pop: assert property (s_ret |=> s_pop3)
		else $error("return did not pop three bytes");
	a_push_down: assert property (STALL && DM_WE ##1 STALL && DM_WE |-> DM_ADDR == $past(DM_ADDR) - 16'h1)
		else $error("push address did not step down");
	a_return_from_interrupt_flag: assert property (s_ret ##0 STK_REQ.op == CSRF_OP_RETURN_FROM_INTERRUPT |=> !RETURN_FROM_INTERRUPT_DONE [*2] ##1 RETURN_FROM_INTERRUPT_DONE)
		else $error("interrupt return flag misplaced");
	a_byte_push: assert property (s_push ##1 s_push |-> DM_WE && DM_ADDR == $past(DM_ADDR) - 16'h1)
		else $error("byte push did not step down by one");
	a_block_set: assert property (quiet && IO_WR.we && IO_WR.addr == CSRF_IO_SP_LO && STK_REQ.op == CSRF_OP_NONE |=> IRQ_BLOCK)
		else $error("low byte write did not block interrupts");
	a_irq_masked: assert property (IRQ_BLOCK && STK_REQ.op == CSRF_OP_IRQ |-> !IRQ_ACK ##1 !STALL)
		else $error("interrupt taken while blocked");
	a_block_end: assert property (IRQ_BLOCK && IO_WR.we && IO_WR.addr != CSRF_IO_SP_LO |=> !IRQ_BLOCK)
		else $error("other write did not end the block");
	a_table_byte: assert property (quiet && LPM_REQ |=> LPM_VALID && LPM_DATA == ($past(PTR_Z[0]) ? $past(PM_DATA[15:8]) : $past(PM_DATA[7:0])))
		else $error("table byte wrong");
endmodule
bind csrf_core csrf_core_checker #(.PC_W(PC_W)) csrf_core_checker_i (.*);
`default_nettype wire

// file: verif/csrf_mem_model.sv
// Program and data memory on the far side of the core block
`timescale 1ns/1ps
`default_nettype none
module csrf_mem_model #(
	parameter int PC_W = 17
) (
	input  wire logic            clk,
	input  wire logic [PC_W-1:0] pm_addr,
	output logic [15:0]          pm_data,
	input  wire logic [15:0]     dm_addr,
	input  wire logic [7:0]      dm_wdata,
	input  wire logic            dm_we,
	input  wire logic            dm_re,
	output logic [7:0]           dm_rdata
);
	logic [7:0] mem [65536];
	logic [7:0] last_r = 8'h00;
	// Word depends on every address bit so a misplaced fetch is seen
	function automatic logic [15:0] pw(logic [PC_W-1:0] a);
		return {a[7:0] ^ 8'hA5, a[15:8] ^ 8'(a >> 16) ^ 8'h3C};
	endfunction
	assign pm_data = pw(pm_addr);
	always @(posedge clk) begin
		if (dm_we)
			mem[dm_addr] <= dm_wdata;
		if (dm_re)
			last_r <= dm_rdata;
	end
	// A released bus shows the inverse of its last byte, never a stale copy
	always_comb begin
		if (!dm_re)
			dm_rdata = ~last_r;
		else
			dm_rdata = mem[dm_addr];
	end
endmodule
`default_nettype wire

// file: verif/cpu_stack_and_register_file_test.sv
// Self-checking bench for the core stack and register block
`timescale 1ns/1ps
`default_nettype none
module cpu_stack_and_register_file_test;
	import csrf_pkg::*;
	logic          clk, rst_n, ex_long, insn_done, lpm_req, insn_valid, insn_ext, stall;
	logic          lpm_valid, irq_ack, return_from_interrupt_done, irq_block, dm_we, dm_re;
	logic [16:0]   pm_addr, insn_addr, ret;
	logic [15:0]   pm_data, insn, word_a, ptr_x, ptr_y, ptr_z, dm_addr, sp, s0;
	logic [7:0]    rd_a, rd_b, lpm_data, io_rd_addr, io_rdata, dm_wdata, dm_rdata;
	logic [7:0]    regs [32];
	csrf_rf_req_s  rf;
	csrf_stk_req_s stk;
	csrf_io_wr_s   io;
	int            fails, comparisons, cyc, dones;
	csrf_core csrf_core_i (.CLOCK(clk), .RST_N(rst_n), .PM_ADDR(pm_addr), .PM_DATA(pm_data),
		.INSN(insn), .INSN_VALID(insn_valid), .INSN_EXT(insn_ext), .INSN_ADDR(insn_addr),
		.EX_LONG(ex_long), .INSN_DONE(insn_done), .STALL(stall), .RF_REQ(rf),
		.RF_RDATA_A(rd_a), .RF_RDATA_B(rd_b), .RF_WORD_A(word_a), .PTR_X(ptr_x),
		.PTR_Y(ptr_y), .PTR_Z(ptr_z), .LPM_REQ(lpm_req), .LPM_DATA(lpm_data),
		.LPM_VALID(lpm_valid), .STK_REQ(stk), .IRQ_ACK(irq_ack), .RETURN_FROM_INTERRUPT_DONE(return_from_interrupt_done),
		.IRQ_BLOCK(irq_block), .IO_WR(io), .IO_RD_ADDR(io_rd_addr), .IO_RDATA(io_rdata),
		.DM_ADDR(dm_addr), .DM_WDATA(dm_wdata), .DM_WE(dm_we), .DM_RE(dm_re),
		.DM_RDATA(dm_rdata));
	csrf_mem_model csrf_mem_model_i (.*);
	task automatic chk(string what, logic [47:0] exp, logic [47:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic get_sp();
		io_rd_addr = CSRF_IO_SP_LO;
		#1 sp[7:0] = io_rdata;
		io_rd_addr = CSRF_IO_SP_HI;
		#1 sp[15:8] = io_rdata;
	endtask
	task automatic op(csrf_op_e o);
		@(negedge clk);
		stk = '{o, 5'h0, 24'(17'($urandom))};
		#1 chk("ack", o == CSRF_OP_IRQ && irq_block === 1'b0, irq_ack);
		if (o inside {CSRF_OP_CALL, CSRF_OP_IRQ})
			ret = (o == CSRF_OP_CALL || insn_valid !== 1'b1) ? pm_addr : insn_addr;
		@(negedge clk);
		stk.op = CSRF_OP_NONE;
		for (int i = 0; i < 8 && stall === 1'b1; i++)
			@(negedge clk);
		get_sp();
	endtask
	task automatic rf_wr(logic [4:0] a, logic [15:0] d, logic w);
		@(negedge clk);
		rf = '{5'h0, 5'h0, 1'b1, w, a, d};
		if (w)
			{regs[a | 5'h1], regs[a & 5'h1E]} = d;
		else
			regs[a] = d[7:0];
		@(negedge clk);
		rf.we = 1'b0;
	endtask
	task automatic rf_rd(logic [4:0] a, logic [4:0] b);
		rf.ra = a;
		rf.rb = b;
		#1 chk("rdata", {regs[a], regs[b]}, {rd_a, rd_b});
		chk("word_a", {regs[a | 5'h1], regs[a & 5'h1E]}, word_a);
		chk("ptrs", {regs[27], regs[26], regs[29], regs[28], regs[31], regs[30]}, {ptr_x, ptr_y, ptr_z});
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Sampled mid-cycle so the pulse is read where it is settled
	always @(negedge clk) begin
		cyc++;
		if (return_from_interrupt_done === 1'b1)
			dones++;
		if (cyc == 5000) begin
			fails++;
			wrap_up();
		end
	end
	initial begin
		void'($urandom(94197));
		{rst_n, ex_long, insn_done, lpm_req} = '0;
		rf = '0;
		stk = '0;
		io = '0;
		io_rd_addr = '0;
		foreach (regs[i]) regs[i] = CSRF_REG_RST;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		get_sp();
		chk("sp_reset", CSRF_SRAM_TOP_DFLT, sp);
		for (int i = 0; i < 20; i++) begin
			@(negedge clk);
			ex_long = (i == 5);
			#1 if (insn_valid === 1'b1 && insn_ext === 1'b0)
				chk("insn", {csrf_mem_model_i.pw(insn_addr), insn_addr + 17'h1}, {insn, pm_addr});
			if (i == 6)
				chk("insn_ext", 1'b1, insn_ext);
		end
		ret = 17'($urandom);
		@(negedge clk);
		stk = '{CSRF_OP_JUMP, 5'h0, 24'(ret)};
		@(negedge clk);
		stk.op = CSRF_OP_NONE;
		chk("jump_flush", 1'b0, insn_valid);
		@(negedge clk);
		chk("jump_fetch", {1'b1, ret}, {insn_valid, insn_addr});
		// First write lands on the top pair, the odd-index corner of a wide write
		for (int i = 0; i < 40; i++) begin
			rf_wr(i == 0 ? 5'h1F : 5'($urandom), 16'($urandom), i == 0 || $urandom % 2);
			rf_rd(5'($urandom), 5'($urandom));
		end
		for (int i = 0; i < 2; i++) begin
			rf_wr(5'h1E, (16'($urandom) & 16'hFFFE) | 16'(i), 1'b1);
			lpm_req = 1'b1;
			@(negedge clk);
			lpm_req = 1'b0;
			chk("lpm", {1'b1, 8'(csrf_mem_model_i.pw({1'b0, ptr_z[15:1]}) >> {ptr_z[0], 3'h0})}, {lpm_valid, lpm_data});
		end
		get_sp();
		s0 = sp;
		@(negedge clk);
		rf.ra = 5'h3;
		stk.op = CSRF_OP_PUSH;
		#1 chk("push", {s0, regs[3]}, {dm_addr, dm_wdata});
		@(negedge clk);
		rf.ra = 5'h4;
		#1 chk("push2", {s0 - 16'h1, regs[4]}, {dm_addr, dm_wdata});
		@(negedge clk);
		stk = '{CSRF_OP_POP, 5'h7, 24'h0};
		#1 chk("pop_addr", s0 - 16'h1, dm_addr);
		@(negedge clk);
		stk.reg_idx = 5'h8;
		#1 chk("pop_addr2", s0, dm_addr);
		@(negedge clk);
		stk.op = CSRF_OP_NONE;
		regs[7] = regs[4];
		regs[8] = regs[3];
		rf_rd(5'h7, 5'h8);
		get_sp();
		chk("sp_pop", s0, sp);
		for (int k = 0; k < 2; k++) begin
			s0 = sp;
			op(k ? CSRF_OP_IRQ : CSRF_OP_CALL);
			chk("sp_call", s0 - 16'h3, sp);
			chk("ret_bytes", {ret[7:0], 7'h0, ret[16]}, {csrf_mem_model_i.mem[s0], csrf_mem_model_i.mem[s0 - 16'h2]});
			op(k ? CSRF_OP_RETURN_FROM_INTERRUPT : CSRF_OP_RET);
			chk("sp_ret", s0, sp);
			for (int i = 0; i < 4 && insn_valid !== 1'b1; i++)
				@(negedge clk);
			chk("resume", ret, insn_addr);
		end
		chk("return_from_interrupt_done", 1, dones);
		// Rewrite the same low byte so the pointer stays above 0x2000
		@(negedge clk);
		io = '{1'b1, CSRF_IO_SP_LO, sp[7:0]};
		@(negedge clk);
		io.we = 1'b0;
		op(CSRF_OP_IRQ);
		for (int i = 0; i < 4; i++) begin
			chk("blocked", 1'b1, irq_block);
			insn_done = 1'b1;
			@(negedge clk);
			insn_done = 1'b0;
			@(negedge clk);
		end
		chk("unblocked", 1'b0, irq_block);
		io = '{1'b1, CSRF_IO_SP_LO, sp[7:0]};
		@(negedge clk);
		chk("reblocked", 1'b1, irq_block);
		io.addr = 8'h10;
		@(negedge clk);
		io.we = 1'b0;
		#1 chk("io_clear", 1'b0, irq_block);
		wrap_up();
	end
endmodule
`default_nettype wire
